/* File: rtl/oca_otp_access.sv */
`include "oca_map.svh"

module oca_otp_access
    import oca_pkg::*;
#(
    // arbitrary identification values
    parameter logic [1:0] REV_MASK    = 2'h0,
    parameter logic [1:0] REV_METAL   = 2'h0,
    parameter logic       REV_FAMILY  = 1'h0,
    parameter logic       REV_PACKAGE = 1'h0
) (
    input  wire logic        ref_clk,
    input  wire logic        srst,
    // register port
    input  wire logic [4:0]  reg_addr,
    input  wire logic [7:0]  reg_wdata,
    input  wire logic        reg_wr,
    input  wire logic        reg_rd,
    output logic      [7:0]  reg_rdata,
    output logic      [9:0]  otp_data,
    // configuration contents to program
    input  wire logic [7:0]  cfg_ch1_voltage_threshold,
    input  wire logic [1:0]  cfg_ch1_current_sense_threshold,
    input  wire logic [7:0]  cfg_ch2_voltage_threshold,
    input  wire logic [1:0]  cfg_ch2_current_sense_threshold,
    input  wire logic [4:0]  cfg_ch1_off_time,
    input  wire logic [4:0]  cfg_ch2_off_time,
    input  wire logic        cfg_ch1_enable,
    input  wire logic        cfg_ch2_enable,
    input  wire logic [2:0]  cfg_failsafe_mode_select,
    input  wire logic        cfg_ch1_thermal_auto_recover,
    input  wire logic        cfg_ch2_thermal_auto_recover,
    input  wire logic [1:0]  cfg_overcurrent_threshold,
    // analog undervoltage comparator, asynchronous
    input  wire logic        program_supply_undervoltage,
    // store contents as defaults
    output logic [7:0]       otp_ch1_voltage_threshold,
    output logic [1:0]       otp_ch1_current_sense_threshold,
    output logic [7:0]       otp_ch2_voltage_threshold,
    output logic [1:0]       otp_ch2_current_sense_threshold,
    output logic [4:0]       otp_ch1_off_time,
    output logic [4:0]       otp_ch2_off_time,
    output logic             otp_ch1_enable,
    output logic             otp_ch2_enable,
    output logic [2:0]       otp_failsafe_mode_select,
    output logic             otp_ch1_thermal_auto_recover,
    output logic             otp_ch2_thermal_auto_recover,
    output logic [1:0]       otp_overcurrent_threshold,
    output logic             otp_locked,
    output logic             otp_busy,
    // store macro
    output logic             mem_read,
    output logic             mem_program,
    output logic [39:0]      mem_wdata,
    output logic             mem_bias_l,
    output logic             mem_bias_h,
    input  wire logic [39:0] mem_rdata,
    input  wire logic        mem_done
);

    // ======================================================
    // slice decode
    function automatic logic [9:0] slice_of(input logic [39:0] s, input logic [1:0] sel);
        slice_of = s[10*sel +: 10];
    endfunction : slice_of

    oca_regs_t r_q;
    oca_regs_t r_d;

    logic       busy;
    logic       wr_ctrl;
    logic [1:0] op;
    logic [7:0] rev;

    // ======================================================
    // next state
    always_comb begin
        r_d      = r_q;
        busy     = (r_q.state != OCA_IDLE);
        wr_ctrl  = reg_wr && (reg_addr == `OCA_ADDR_CTRL);
        op       = reg_wdata[`OCA_CTRL_OP_LSB +: 2];
        rev      = {2'h0, REV_FAMILY, REV_MASK, REV_PACKAGE, REV_METAL};
        r_d.uv_s1 = program_supply_undervoltage;
        r_d.uv_s2 = r_q.uv_s1;

        if (wr_ctrl) begin
            r_d.slice  = reg_wdata[`OCA_CTRL_SLICE_LSB +: 2];
            r_d.bias_l = reg_wdata[`OCA_CTRL_BIAS_L];
            r_d.bias_h = reg_wdata[`OCA_CTRL_BIAS_H];
        end

        // read data; fail flag clears on read, a new event below wins
        if (reg_rd) begin
            case (reg_addr)
                `OCA_ADDR_CTRL: begin
                    r_d.rdata = {2'h0, r_q.bias_h, r_q.bias_l, r_q.slice, 2'h0};
                end
                `OCA_ADDR_STATUS: begin
                    r_d.rdata = {5'h00, r_q.shadow[`OCA_LOCK_BIT], r_q.fail, busy};
                    r_d.fail  = 1'b0;
                end
                `OCA_ADDR_DATA: begin
                    r_d.rdata = r_q.data_rd[7:0];
                end
                `OCA_ADDR_REVISION: begin
                    r_d.rdata = rev;
                end
                default: begin
                    r_d.rdata = 8'h00;
                end
            endcase
        end

        case (r_q.state)
            OCA_IDLE: begin
                // commands while busy never reach here
                if (wr_ctrl && !busy) begin
                    if (op == `OCA_OP_REFRESH) begin
                        r_d.state    = OCA_READ;
                        r_d.mem_read = 1'b1;
                    end else if (op == `OCA_OP_ZAP && !r_q.shadow[`OCA_LOCK_BIT]) begin
                        r_d.state    = OCA_PROG;
                        r_d.mem_prog = 1'b1;
                        // lock bit goes in with the image
                        r_d.wdata = {1'b1, cfg_overcurrent_threshold,
                                     cfg_ch2_thermal_auto_recover,
                                     cfg_ch1_thermal_auto_recover,
                                     cfg_failsafe_mode_select, cfg_ch2_enable,
                                     cfg_ch1_enable, cfg_ch2_off_time, cfg_ch1_off_time,
                                     cfg_ch2_current_sense_threshold,
                                     cfg_ch2_voltage_threshold,
                                     cfg_ch1_current_sense_threshold,
                                     cfg_ch1_voltage_threshold};
                    end
                end
            end
            OCA_READ: begin
                if (mem_done) begin
                    r_d.shadow   = mem_rdata;
                    r_d.mem_read = 1'b0;
                    r_d.state    = OCA_IDLE;
                end
            end
            OCA_PROG: begin
                if (r_q.uv_s2) begin
                    r_d.fail = 1'b1;
                end
                if (mem_done) begin
                    // lock taken at once; rest visible after a refresh
                    r_d.shadow[`OCA_LOCK_BIT] = 1'b1;
                    r_d.mem_prog = 1'b0;
                    r_d.state    = OCA_IDLE;
                end
            end
            default: begin
                r_d.state = OCA_IDLE;
            end
        endcase

        // busy gets its own flop so the pin has no gate behind it
        r_d.active  = r_d.mem_read | r_d.mem_prog;

        r_d.data_rd = slice_of(r_d.shadow, r_d.slice);
    end

    // ======================================================
    // state register; power-up starts with a reload
    always_ff @(posedge ref_clk) begin
        if (srst) begin
            r_q          <= '0;
            r_q.state    <= OCA_READ;
            r_q.mem_read <= 1'b1;
            r_q.active   <= 1'b1;
            r_q.shadow   <= `OCA_RST_STORE;
            r_q.slice    <= `OCA_RST_SLICE;
            r_q.bias_l   <= `OCA_RST_BIAS;
            r_q.bias_h   <= `OCA_RST_BIAS;
        end else begin
            r_q <= r_d;
        end
    end

    // ======================================================
    // outputs, all from flops
    assign reg_rdata                       = r_q.rdata;
    assign otp_data                        = r_q.data_rd;
    assign otp_ch1_voltage_threshold       = r_q.shadow[7:0];
    assign otp_ch1_current_sense_threshold = r_q.shadow[9:8];
    assign otp_ch2_voltage_threshold       = r_q.shadow[17:10];
    assign otp_ch2_current_sense_threshold = r_q.shadow[19:18];
    assign otp_ch1_off_time                = r_q.shadow[24:20];
    assign otp_ch2_off_time                = r_q.shadow[29:25];
    assign otp_ch1_enable                  = r_q.shadow[30];
    assign otp_ch2_enable                  = r_q.shadow[31];
    assign otp_failsafe_mode_select        = r_q.shadow[34:32];
    assign otp_ch1_thermal_auto_recover    = r_q.shadow[35];
    assign otp_ch2_thermal_auto_recover    = r_q.shadow[36];
    assign otp_overcurrent_threshold       = r_q.shadow[38:37];
    assign otp_locked                      = r_q.shadow[`OCA_LOCK_BIT];
    assign otp_busy                        = r_q.active;
    assign mem_read                        = r_q.mem_read;
    assign mem_program                     = r_q.mem_prog;
    assign mem_wdata                       = r_q.wdata;
    // margin bias passed straight to the array read
    assign mem_bias_l                      = r_q.bias_l;
    assign mem_bias_h                      = r_q.bias_h;

endmodule : oca_otp_access

/* File: rtl/oca_map.svh */
`ifndef OCA_MAP_SVH
`define OCA_MAP_SVH

// ==========================================================
// register offsets
`define OCA_ADDR_CTRL      5'h1A
`define OCA_ADDR_STATUS    5'h1B
`define OCA_ADDR_DATA      5'h1E
`define OCA_ADDR_REVISION  5'h1F

// ==========================================================
// control register fields
`define OCA_CTRL_OP_LSB    0
`define OCA_CTRL_SLICE_LSB 2
`define OCA_CTRL_BIAS_L    4
`define OCA_CTRL_BIAS_H    5

// ==========================================================
// status register fields
`define OCA_STAT_BUSY      0
`define OCA_STAT_FAIL      1
`define OCA_STAT_LOCK      2

// ==========================================================
// operation codes
`define OCA_OP_NOP0        2'h0
`define OCA_OP_REFRESH     2'h1
`define OCA_OP_ZAP         2'h2
`define OCA_OP_NOP3        2'h3

// ==========================================================
// store layout
`define OCA_STORE_BITS     40
`define OCA_SLICE_BITS     10
`define OCA_LOCK_BIT       39

// ==========================================================
// reset values
`define OCA_RST_SLICE      2'h0
`define OCA_RST_BIAS       1'h0
`define OCA_RST_STORE      40'h00_0000_0000

`endif

/* File: rtl/oca_pkg.sv */
package oca_pkg;

    typedef enum logic [1:0] {
        OCA_IDLE,
        OCA_READ,
        OCA_PROG
    } oca_state_t;

    typedef struct packed {
        oca_state_t  state;
        logic [39:0] shadow;
        logic [39:0] wdata;
        logic [1:0]  slice;
        logic        bias_l;
        logic        bias_h;
        logic        fail;
        logic        uv_s1;
        logic        uv_s2;
        logic        mem_read;
        logic        mem_prog;
        logic        active;
        logic [7:0]  rdata;
        logic [9:0]  data_rd;
    } oca_regs_t;

endpackage : oca_pkg

/* File: verif/oca_otp_access_checker.sv */
`include "oca_map.svh"
// ==========================================================
// port checks
module oca_otp_access_checker (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic [4:0]  reg_addr,
    input wire logic [7:0]  reg_wdata,
    input wire logic        reg_wr,
    input wire logic        otp_busy,
    input wire logic        otp_locked,
    input wire logic        mem_read,
    input wire logic        mem_program,
    input wire logic        mem_done,
    input wire logic [39:0] mem_wdata
);
    timeunit 1ns;
    timeprecision 1ps;
    default clocking @(posedge ref_clk); endclocking
    default disable iff (srst);
    wire logic ctl = reg_wr && reg_addr == `OCA_ADDR_CTRL;
    chk_busy_during: assert property ((mem_read || mem_program) |-> otp_busy)
        else $error("busy low during op");
    chk_refresh_start: assert property (ctl && reg_wdata[1:0] == 2'h1 && !otp_busy
        |=> mem_read && otp_busy) else $error("refresh not started");
    chk_nop_codes: assert property (ctl && reg_wdata[0] == reg_wdata[1] && !otp_busy
        |=> !otp_busy) else $error("nop started op");
    chk_zap_start: assert property (ctl && reg_wdata[1:0] == 2'h2 && !otp_busy
        && !otp_locked |=> mem_program && mem_wdata[39]) else $error("zap not started");
    chk_zap_locked: assert property (ctl && otp_locked |=> !mem_program)
        else $error("zap while locked");
    chk_busy_ignore: assert property (otp_busy && !mem_done && ctl
        |=> $stable({mem_read, mem_program})) else $error("cmd taken while busy");
    chk_op_end: assert property (mem_done && otp_busy
        |=> !otp_busy && !mem_read && !mem_program) else $error("op not ended");
    chk_image_hold: assert property (mem_program && !mem_done
        |=> mem_program && $stable(mem_wdata)) else $error("image moved");
    cover property (mem_read && mem_done);
    cover property (mem_program && mem_done);
    cover property (ctl && otp_locked && reg_wdata[1:0] == 2'h2);
endmodule : oca_otp_access_checker

bind oca_otp_access oca_otp_access_checker u_chk (.*);

/* File: verif/oca_store_model.sv */
// ==========================================================
// one-time store macro
module oca_store_model (
    input wire logic        ref_clk,
    input wire logic        srst,
    input wire logic        mem_read,
    input wire logic        mem_program,
    input wire logic [39:0] mem_wdata,
    input wire logic [3:0]  lat,
    output logic     [39:0] mem_rdata,
    output logic            mem_done
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [39:0] store_q = 40'h00_0000_0000;
    logic [3:0]  cnt_q = 4'h0;
    logic [7:0]  pat_q = 8'h00;
    // bias ignored: a good cell reads the same at either margin
    assign mem_rdata = mem_done ? store_q : {5{pat_q}};
    always_ff @(posedge ref_clk) begin
        pat_q <= pat_q + 8'h01;
        mem_done <= 1'b0;
        if (srst) begin
            cnt_q <= 4'h0;
        end else if ((mem_read || mem_program) && !mem_done) begin
            cnt_q <= cnt_q + 4'h1;
            if (cnt_q >= lat) begin
                cnt_q <= 4'h0;
                mem_done <= 1'b1;
                // cells only ever set
                if (mem_program) store_q <= store_q | mem_wdata;
            end
        end
    end
endmodule : oca_store_model

/* File: verif/oca_otp_access_tb.sv */
`define CHK(nm, e, g) begin n_compared++; if ((g) !== (e)) begin n_fail++; \
    $display("BAD %s exp %h got %h", nm, e, g); end end
// ==========================================================
// bench
module oca_otp_access_tb;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 1'b0;
    logic srst = 1'b1;
    logic [4:0] reg_addr = 5'h00;
    logic [7:0] reg_wdata = 8'h00;
    logic reg_wr = 1'b0;
    logic reg_rd = 1'b0;
    logic program_supply_undervoltage = 1'b0;
    logic [38:0] img = 39'h00_0000_0000;
    logic [3:0] lat = 4'h5;
    logic [7:0] reg_rdata, v;
    logic [9:0] otp_data;
    logic [39:0] mem_wdata, mem_rdata, exp_m;
    wire logic [39:0] map;
    logic otp_busy, mem_read, mem_program, mem_bias_l, mem_bias_h, mem_done;
    logic [31:0] rng = 32'h0000_0018;
    int n_fail = 0;
    int n_compared = 0;
    int cyc = 0;
    // revision values arbitrary
    oca_otp_access #(.REV_MASK(2'h3), .REV_METAL(2'h2), .REV_FAMILY(1'h1)) u_dut (.*,
        .cfg_ch1_voltage_threshold(img[7:0]), .cfg_ch1_current_sense_threshold(img[9:8]),
        .cfg_ch2_voltage_threshold(img[17:10]), .cfg_ch2_current_sense_threshold(img[19:18]),
        .cfg_ch1_off_time(img[24:20]), .cfg_ch2_off_time(img[29:25]),
        .cfg_ch1_enable(img[30]), .cfg_ch2_enable(img[31]),
        .cfg_failsafe_mode_select(img[34:32]), .cfg_ch1_thermal_auto_recover(img[35]),
        .cfg_ch2_thermal_auto_recover(img[36]), .cfg_overcurrent_threshold(img[38:37]),
        .otp_ch1_voltage_threshold(map[7:0]), .otp_ch1_current_sense_threshold(map[9:8]),
        .otp_ch2_voltage_threshold(map[17:10]), .otp_ch2_current_sense_threshold(map[19:18]),
        .otp_ch1_off_time(map[24:20]), .otp_ch2_off_time(map[29:25]),
        .otp_ch1_enable(map[30]), .otp_ch2_enable(map[31]),
        .otp_failsafe_mode_select(map[34:32]), .otp_ch1_thermal_auto_recover(map[35]),
        .otp_ch2_thermal_auto_recover(map[36]), .otp_overcurrent_threshold(map[38:37]),
        .otp_locked(map[39]));
    oca_store_model u_mem (.*);
    initial forever #4 ref_clk = ~ref_clk;
    always @(posedge ref_clk) begin
        cyc <= cyc + 1;
        if (cyc == 3000) begin
            n_fail++;
            finish_test();
        end
    end
    function automatic logic [31:0] xs(input logic [31:0] s);
        logic [31:0] t;
        t = s ^ (s << 13);
        t = t ^ (t >> 17);
        return t ^ (t << 5);
    endfunction : xs
    task automatic wr(input logic [4:0] a, input logic [7:0] d);
        @(posedge ref_clk);
        rng = xs(rng);
        lat <= 4'h5 + {1'b0, rng[2:0]};
        reg_addr <= a;
        reg_wdata <= d;
        reg_wr <= 1'b1;
        @(posedge ref_clk);
        reg_wr <= 1'b0;
        #1;
    endtask : wr
    task automatic rd(input logic [4:0] a);
        @(posedge ref_clk);
        reg_addr <= a;
        reg_rd <= 1'b1;
        @(posedge ref_clk);
        reg_rd <= 1'b0;
        #1 v = reg_rdata;
    endtask : rd
    // bounded: a stuck op shows up as a later mismatch
    task automatic wait_idle;
        repeat (40) if (otp_busy !== 1'b0) begin
            @(posedge ref_clk);
            #1;
        end
    endtask : wait_idle
    task automatic finish_test;
        if (n_fail == 0 && n_compared > 0) $display("Result: passed");
        else $display("Result: failed");
        $finish;
    endtask : finish_test
    initial begin
        repeat (20) @(posedge ref_clk);
        srst <= 1'b0;
        wait_idle();
        rd(5'h1F); `CHK("revision", 8'h3A, v)
        rd(5'h05); `CHK("unmapped", 8'h00, v)
        for (int op = 0; op < 4; op += 3) begin
            wr(5'h1A, op[7:0]); `CHK("nop busy", 1'b0, otp_busy)
        end
        // zap landing mid-reload must be dropped, store stays unlocked
        wr(5'h1A, 8'h01);
        wr(5'h1A, 8'h02);
        wait_idle();
        `CHK("zap in busy lock", 1'b0, map[39])
        `CHK("zap in busy idle", 1'b0, otp_busy)
        rng = xs(rng);
        exp_m[31:0] = rng;
        rng = xs(rng);
        exp_m[39:32] = {1'b1, rng[6:0]};
        @(posedge ref_clk);
        img <= exp_m[38:0];
        program_supply_undervoltage <= 1'b1;
        wr(5'h1A, 8'h02); `CHK("zap image", exp_m, mem_wdata)
        wait_idle();
        @(posedge ref_clk);
        program_supply_undervoltage <= 1'b0;
        rd(5'h1B); `CHK("status fail", 8'h06, v)
        rd(5'h1B); `CHK("status clear", 8'h04, v)
        wr(5'h1A, 8'h02); `CHK("relock", 1'b0, otp_busy)
        for (int b = 1; b < 4; b++) for (int s = 0; s < 4; s++) begin
            wr(5'h1A, {2'b00, b[1:0], s[1:0], 2'b01}); `CHK("busy", 1'b1, otp_busy)
            `CHK("bias", b[1:0], {mem_bias_h, mem_bias_l})
            wait_idle();
            `CHK("slice", exp_m[s * 10 +: 10], otp_data)
            rd(5'h1E); `CHK("data reg", exp_m[s * 10 +: 8], v)
        end
        wr(5'h1A, 8'h01);
        wr(5'h1A, 8'h01);
        wait_idle();
        repeat (2) @(posedge ref_clk);
        #1 `CHK("one op", 1'b0, otp_busy)
        @(posedge ref_clk);
        srst <= 1'b1;
        repeat (3) @(posedge ref_clk);
        srst <= 1'b0;
        wait_idle();
        `CHK("defaults", exp_m, map)
        finish_test();
    end
endmodule : oca_otp_access_tb
